// file: logic/lhp_defs.vh
/*
 constants for the host bus port of the network controller.
 assumes inclusion by bare name from the design files.
*/
`ifndef LHP_DEFS_VH
`define LHP_DEFS_VH
`define LHP_RESET_MIN_CYCLES 7
`define LHP_BLOCK_BYTES 4
`define LHP_REG_CONTROL 2'h0
`define LHP_REG_ADDR_FIFO 2'h3
`define LHP_CTRL_CMDRQ 0
`define LHP_CTRL_CLRIRQ 3
`define LHP_STAT_BUSY 1
`define LHP_STAT_IRQ 4
`endif

// file: logic/lhp_buf2.v
/*
 two-entry buffer with valid and ready on both sides.
 assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module lhp_buf2 #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg rd_ff;
  reg wr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clock) begin
    if (reset) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
  always @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: logic/lhp_edge.v
/*
 rising edge detector for a level input.
 assumes input synchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module lhp_edge (
  input wire clock,
  input wire reset,
  input wire level,
  output wire rise
);
  reg last_ff;
  assign rise = level & ~last_ff;
  always @(posedge clock) begin
    if (reset) begin
      last_ff <= 1'b1;
    end else begin
      last_ff <= level;
    end
  end
endmodule
`default_nettype wire

// file: logic/lhp_host_port.v
/*
 host bus port: i/o slave registers and dma bus master for 4-byte blocks.
 assumes synchronous inputs; tristate wires resolved outside from enables.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lhp_defs.vh"
module lhp_host_port #(
  parameter BLOCK_BYTES = `LHP_BLOCK_BYTES
) (
  input wire clock,
  input wire reset,
  input wire reset_n_pin,
  input wire chip_select_n,
  input wire rd_n_in,
  output reg rd_n_out,
  output reg rd_n_oe,
  input wire wr_n_in,
  output reg wr_n_out,
  output reg wr_n_oe,
  input wire byte_word,
  output reg bus_hold_request,
  input wire bus_hold_grant,
  output reg upper_address_gate,
  output reg upper_address_strobe,
  input wire ready,
  input wire high_lane_enable_n_in,
  output reg high_lane_enable_n_out,
  output reg high_lane_enable_n_oe,
  input wire [1:0] addr_lo_in,
  output reg [1:0] addr_lo_out,
  output reg addr_lo_oe,
  output reg [5:0] addr_mid_out,
  output reg addr_mid_oe,
  input wire [7:0] low_lane_addr_hi_in,
  output reg [7:0] low_lane_addr_hi_out,
  output reg low_lane_addr_hi_oe,
  input wire [7:0] high_lane_addr_mid_in,
  output reg [7:0] high_lane_addr_mid_out,
  output reg high_lane_addr_mid_oe,
  input wire command_request,
  input wire irq_clear,
  output reg irq,
  input wire dma_start,
  input wire dma_write,
  input wire [23:0] dma_addr,
  input wire packet_received,
  input wire command_done,
  input wire wr_valid,
  output wire wr_ready,
  input wire [15:0] wr_data,
  output wire rd_valid,
  input wire rd_ready,
  output wire [15:0] rd_data,
  output reg command_pending,
  output reg [23:0] command_addr,
  output reg dma_busy
);
  localparam S_IDLE = 6'h01;
  localparam S_REQ = 6'h02;
  localparam S_ADDR = 6'h04;
  localparam S_STRB = 6'h08;
  localparam S_WAIT = 6'h10;
  localparam S_DONE = 6'h20;
  reg [5:0] st_ff;
  reg [23:0] addr_ff;
  reg [2:0] left_ff;
  reg dir_ff;
  reg [7:0] afifo_ff;
  reg [7:0] slave_rd_ff;
  reg slave_oe_ff;
  reg slave_wr_ff;
  wire rise_cmd;
  wire rise_clr;
  wire rise_cmd_bit;
  wire rise_clr_bit;
  wire slave_wr;
  wire slave_rd;
  wire wide;
  wire cap_valid;
  wire cap_ready;
  reg [15:0] cap_data;
  wire wb_valid;
  wire [15:0] wb_data;
  reg wb_pop;
  wire [2:0] step;
  function [2:0] step_of;
    input w;
    input a0;
    begin
      step_of = (w & ~a0) ? 3'h2 : 3'h1;
    end
  endfunction
  assign wide = byte_word;
  assign step = step_of(wide, addr_ff[0]);
  assign slave_wr = ~st_ff[2] & ~st_ff[3] & ~st_ff[4] & ~chip_select_n & ~wr_n_in;
  assign slave_rd = ~st_ff[2] & ~st_ff[3] & ~st_ff[4] & ~chip_select_n & ~rd_n_in;
  lhp_edge u_cmd (.clock(clock), .reset(reset), .level(command_request), .rise(rise_cmd));
  lhp_edge u_clr (.clock(clock), .reset(reset), .level(irq_clear), .rise(rise_clr));
  lhp_edge u_cmdb (.clock(clock), .reset(reset),
    .level(slave_wr & (addr_lo_in == `LHP_REG_CONTROL) & low_lane_addr_hi_in[`LHP_CTRL_CMDRQ]),
    .rise(rise_cmd_bit));
  lhp_edge u_clrb (.clock(clock), .reset(reset),
    .level(slave_wr & (addr_lo_in == `LHP_REG_CONTROL) & low_lane_addr_hi_in[`LHP_CTRL_CLRIRQ]),
    .rise(rise_clr_bit));
  assign cap_valid = st_ff[4] & ready & ~dir_ff;
  lhp_buf2 #(.WIDTH(16)) u_rdbuf (.clock(clock), .reset(reset), .in_valid(cap_valid), .in_ready(cap_ready),
    .in_data(cap_data), .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_data));
  lhp_buf2 #(.WIDTH(16)) u_wrbuf (.clock(clock), .reset(reset), .in_valid(wr_valid), .in_ready(wr_ready),
    .in_data(wr_data), .out_valid(wb_valid), .out_ready(wb_pop), .out_data(wb_data));
  always @* begin
    cap_data = 16'h0000;
    if (~high_lane_enable_n_in & wide & ~addr_ff[0]) begin
      cap_data = {high_lane_addr_mid_in, low_lane_addr_hi_in};
    end else if (addr_ff[0] & wide) begin
      cap_data = {8'h00, high_lane_addr_mid_in};
    end else begin
      cap_data = {8'h00, low_lane_addr_hi_in};
    end
    wb_pop = st_ff[4] & ready & dir_ff;
  end
  always @(posedge clock) begin
    if (reset | ~reset_n_pin) begin
      st_ff <= S_IDLE;
      addr_ff <= 24'h000000;
      left_ff <= 3'h0;
      dir_ff <= 1'b0;
      irq <= 1'b0;
      command_pending <= 1'b0;
      command_addr <= 24'h000000;
      afifo_ff <= 8'h00;
      dma_busy <= 1'b0;
      slave_rd_ff <= 8'h00;
      slave_oe_ff <= 1'b0;
      slave_wr_ff <= 1'b0;
    end else begin
      if (command_done | packet_received) begin
        irq <= 1'b1;
      end else if (rise_clr | rise_clr_bit) begin
        irq <= 1'b0;
      end
      if (rise_cmd | rise_cmd_bit) begin
        command_pending <= 1'b1;
      end else if (command_done) begin
        command_pending <= 1'b0;
      end
      slave_wr_ff <= slave_wr;
      if (slave_wr & ~slave_wr_ff & (addr_lo_in == `LHP_REG_ADDR_FIFO) & (high_lane_enable_n_in | ~addr_lo_in[0])) begin
        afifo_ff <= low_lane_addr_hi_in;
        command_addr <= {command_addr[15:0], low_lane_addr_hi_in};
      end
      slave_oe_ff <= slave_rd;
      slave_rd_ff <= 8'h00;
      slave_rd_ff[`LHP_STAT_IRQ] <= irq;
      slave_rd_ff[`LHP_STAT_BUSY] <= dma_busy;
      case (st_ff)
        S_IDLE: begin
          if (dma_start) begin
            st_ff <= S_REQ;
            addr_ff <= dma_addr;
            dir_ff <= dma_write;
            left_ff <= BLOCK_BYTES[2:0];
            dma_busy <= 1'b1;
          end
        end
        S_REQ: begin
          if (bus_hold_grant & (~dir_ff | wb_valid)) begin
            st_ff <= S_ADDR;
          end
        end
        S_ADDR: begin
          st_ff <= S_STRB;
        end
        S_STRB: begin
          st_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (ready & (dir_ff | cap_ready)) begin
            addr_ff <= addr_ff + {21'h000000, step};
            if (left_ff <= step) begin
              st_ff <= S_DONE;
            end else begin
              left_ff <= left_ff - step;
              st_ff <= (dir_ff & ~wb_valid) ? S_REQ : S_ADDR;
            end
          end
        end
        S_DONE: begin
          st_ff <= S_IDLE;
          dma_busy <= 1'b0;
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end
  always @* begin
    bus_hold_request = st_ff[1] | st_ff[2] | st_ff[3] | st_ff[4];
    upper_address_gate = st_ff[2] | st_ff[3] | st_ff[4];
    upper_address_strobe = st_ff[2];
    rd_n_oe = upper_address_gate;
    wr_n_oe = upper_address_gate;
    rd_n_out = ~(st_ff[4] & ~dir_ff);
    wr_n_out = ~(st_ff[4] & dir_ff);
    addr_lo_oe = upper_address_gate;
    addr_lo_out = addr_ff[1:0];
    addr_mid_oe = upper_address_gate;
    addr_mid_out = addr_ff[7:2];
    high_lane_enable_n_oe = upper_address_gate & wide;
    high_lane_enable_n_out = ~(wide & (addr_ff[0] | (left_ff >= 3'h2)));
    low_lane_addr_hi_oe = slave_oe_ff | st_ff[2] | ((st_ff[3] | st_ff[4]) & dir_ff);
    high_lane_addr_mid_oe = st_ff[2] | ((st_ff[3] | st_ff[4]) & dir_ff & wide);
    low_lane_addr_hi_out = slave_rd_ff;
    high_lane_addr_mid_out = addr_ff[15:8];
    if (st_ff[2]) begin
      low_lane_addr_hi_out = addr_ff[23:16];
    end else if (st_ff[3] | st_ff[4]) begin
      low_lane_addr_hi_out = wb_data[7:0];
      high_lane_addr_mid_out = addr_ff[0] ? wb_data[7:0] : wb_data[15:8];
    end
  end
endmodule
`default_nettype wire

// file: dv/lhp_monitor.sv
/*
 bus rule checker for the host port.
 assumes binding to lhp_host_port ports by name.
*/
`timescale 1ns/100ps
`default_nettype none
module lhp_monitor (
  input wire logic clock,
  reset,
  reset_n_pin,
  dma_start,
  dma_busy,
  bus_hold_request,
  bus_hold_grant,
  upper_address_gate,
  upper_address_strobe,
  rd_n_out,
  rd_n_oe,
  wr_n_out,
  wr_n_oe,
  ready,
  byte_word,
  high_lane_enable_n_oe,
  addr_lo_oe,
  irq,
  irq_clear,
  command_done,
  packet_received
);
  logic st_lo;
  assign st_lo = (rd_n_oe && !rd_n_out) || (wr_n_oe && !wr_n_out);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_quiet; !reset_n_pin |=> !bus_hold_request && !rd_n_oe && !wr_n_oe && !addr_lo_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("bus driven in reset");
  property p_grant; $rose(upper_address_gate) |-> bus_hold_grant && bus_hold_request; endproperty
  a_grant: assert property (p_grant) else $error("master without grant");
  property p_req; dma_start && !dma_busy && !bus_hold_request |=> bus_hold_request; endproperty
  a_req: assert property (p_req) else $error("no hold request");
  property p_stb; upper_address_strobe |-> upper_address_gate ##1 !upper_address_strobe; endproperty
  a_stb: assert property (p_stb) else $error("bad address strobe");
  property p_wait; st_lo && !ready |=> st_lo; endproperty
  a_wait: assert property (p_wait) else $error("strobe not stretched");
  property p_lane; high_lane_enable_n_oe |-> byte_word && upper_address_gate; endproperty
  a_lane: assert property (p_lane) else $error("lane enable driven");
  property p_clr; $rose(irq_clear) && !command_done && !packet_received |-> ##[1:2] !irq; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_set; command_done || packet_received |=> irq; endproperty
  a_set: assert property (p_set) else $error("irq not set");
  property p_rel; $fell(bus_hold_request) |-> ##[0:1] !rd_n_oe && !wr_n_oe && !addr_lo_oe; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
endmodule
bind lhp_host_port lhp_monitor u_mon (.*);
`default_nettype wire

// file: dv/lhp_mem_model.sv
/*
 far side model: host grant and slow memory.
 assumes the bench resolves lanes and strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module lhp_mem_model (
  input wire logic clock,
  reset,
  slow,
  bus_hold_request,
  upper_address_strobe,
  rd_act,
  wr_act,
  input wire logic [7:0] addr_byte,
  lo_lane,
  hi_lane,
  output logic bus_hold_grant,
  ready,
  output logic [7:0] lo_drv,
  hi_drv,
  last_a,
  output logic [3:0] n_beats,
  output logic [15:0] last_wr,
  upper
);
  logic [1:0] cnt_ff;
  logic tog_ff;
  assign ready = !slow || cnt_ff == 2'h2;
  assign lo_drv = rd_act ? 8'ha5 : {8{tog_ff}};
  assign hi_drv = rd_act ? 8'h5a : {8{!tog_ff}};
  always @(posedge clock) begin
    tog_ff <= !tog_ff;
    bus_hold_grant <= bus_hold_request && !reset;
    cnt_ff <= ((rd_act || wr_act) && !ready) ? cnt_ff + 2'h1 : 2'h0;
    if (upper_address_strobe) upper <= {lo_lane, hi_lane};
    if ((rd_act || wr_act) && ready) begin
      n_beats <= n_beats + 4'h1;
      last_a <= addr_byte;
      if (wr_act) last_wr <= {hi_lane, lo_lane};
    end
    if (reset) begin
      n_beats <= 4'h0;
      cnt_ff <= 2'h0;
      tog_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
/*
 testbench for the host port with memory model.
 assumes word mode and a slow memory.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock, reset, reset_n_pin, cs_n, h_rd_n, h_wr_n, byte_word, dma_start, dma_write, command_request;
  logic irq_clear, packet_received, command_done, wr_valid, rd_ready, slow, rd_n_out, rd_n_oe, wr_n_out;
  logic wr_n_oe, bus_hold_request, bus_hold_grant, upper_address_gate, upper_address_strobe, ready, irq;
  logic high_lane_enable_n_out, high_lane_enable_n_oe, addr_lo_oe, addr_mid_oe, low_lane_addr_hi_oe;
  logic high_lane_addr_mid_oe, wr_ready, rd_valid, command_pending, dma_busy;
  logic [1:0] h_a, addr_lo_out;
  logic [5:0] addr_mid_out;
  logic [7:0] h_d, q, lo, hi, lo_drv, hi_drv, last_a, low_lane_addr_hi_out, high_lane_addr_mid_out;
  logic [3:0] n_beats;
  logic [15:0] wr_data, rd_data, last_wr, upper;
  logic [23:0] dma_addr, command_addr;
  int n_fail, num_checks, i;
  assign lo = low_lane_addr_hi_oe ? low_lane_addr_hi_out : (cs_n ? lo_drv : h_d);
  assign hi = high_lane_addr_mid_oe ? high_lane_addr_mid_out : hi_drv;
  lhp_host_port u_dut (.clock, .reset, .reset_n_pin, .chip_select_n(cs_n), .rd_n_in(rd_n_oe ? rd_n_out : h_rd_n),
    .rd_n_out, .rd_n_oe, .wr_n_in(wr_n_oe ? wr_n_out : h_wr_n), .wr_n_out, .wr_n_oe, .byte_word,
    .bus_hold_request, .bus_hold_grant, .upper_address_gate, .upper_address_strobe, .ready,
    .high_lane_enable_n_in(high_lane_enable_n_oe ? high_lane_enable_n_out : 1'b1), .high_lane_enable_n_out,
    .high_lane_enable_n_oe, .addr_lo_in(addr_lo_oe ? addr_lo_out : h_a), .addr_lo_out, .addr_lo_oe,
    .addr_mid_out, .addr_mid_oe, .low_lane_addr_hi_in(lo), .low_lane_addr_hi_out, .low_lane_addr_hi_oe,
    .high_lane_addr_mid_in(hi), .high_lane_addr_mid_out, .high_lane_addr_mid_oe, .command_request, .irq_clear,
    .irq, .dma_start, .dma_write, .dma_addr, .packet_received, .command_done, .wr_valid, .wr_ready, .wr_data,
    .rd_valid, .rd_ready, .rd_data, .command_pending, .command_addr, .dma_busy);
  lhp_mem_model u_mem (.clock, .reset, .slow, .bus_hold_request, .upper_address_strobe,
    .rd_act(rd_n_oe && !rd_n_out), .wr_act(wr_n_oe && !wr_n_out), .addr_byte({addr_mid_out, addr_lo_out}),
    .lo_lane(lo), .hi_lane(hi), .bus_hold_grant, .ready, .lo_drv, .hi_drv, .last_a, .n_beats, .last_wr, .upper);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task finish_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task io(input logic w, input logic [1:0] a, input logic [7:0] d);
    cs_n = 1'b0; h_a = a; h_d = d; h_rd_n = w; h_wr_n = !w;
    cyc(2);
    q = lo;
    cs_n = 1'b1; h_rd_n = 1'b1; h_wr_n = 1'b1;
    cyc(1);
  endtask
  task push(input logic [15:0] d);
    wr_valid = 1'b1; wr_data = d;
    for (i = 0; i < 20 && wr_ready !== 1'b1; i++) cyc(1);
    cyc(1);
    wr_valid = 1'b0;
    chk("push taken", 1'b1, i < 20);
    if (i == 20) finish_test;
    cyc(1);
  endtask
  task run_dma(input logic w);
    dma_write = w; dma_addr = 24'h123450; dma_start = 1'b1;
    cyc(1);
    dma_start = 1'b0;
    cyc(2);
    for (i = 0; i < 200 && dma_busy !== 1'b0; i++) cyc(1);
    chk("dma idle", 1'b0, dma_busy);
    if (i == 200) finish_test;
  endtask
  task t_reset;
    reset_n_pin = 1'b0;
    cyc(7);
    chk("bus drive", 5'h0, {bus_hold_request, rd_n_oe, wr_n_oe, addr_lo_oe, upper_address_gate});
    reset_n_pin = 1'b1;
    cyc(2);
  endtask
  task t_irq;
    command_done = 1'b1; cyc(1); command_done = 1'b0; cyc(1);
    chk("irq", 1'b1, irq);
    io(1'b0, 2'h0, 8'h00);
    chk("status irq", 1'b1, q[4]);
    irq_clear = 1'b1; cyc(3); irq_clear = 1'b0;
    chk("irq", 1'b0, irq);
    packet_received = 1'b1; cyc(1); packet_received = 1'b0; cyc(1);
    chk("irq", 1'b1, irq);
    io(1'b1, 2'h0, 8'h08);
    cyc(2);
    chk("irq", 1'b0, irq);
  endtask
  task t_dma_wr;
    push(16'hbeef); push(16'hc0de);
    chk("wr full", 1'b0, wr_ready);
    run_dma(1'b1);
    chk("beats", 4'h2, n_beats);
    chk("wr data", 16'hc0de, last_wr);
    chk("addr low", 8'h52, last_a);
    chk("upper", 16'h1234, upper);
    chk("wr drained", 1'b1, wr_ready);
  endtask
  task t_dma_rd;
    run_dma(1'b0);
    chk("beats", 4'h4, n_beats);
    repeat (2) begin
      chk("rd data", 16'h5aa5, {rd_valid ? rd_data : 16'h0});
      rd_ready = 1'b1; cyc(1); rd_ready = 1'b0; cyc(1);
    end
    chk("rd empty", 1'b0, rd_valid);
  endtask
  task t_cmd;
    chk("pending", 1'b0, command_pending);
    command_request = 1'b1; cyc(2);
    chk("pending", 1'b1, command_pending);
    command_request = 1'b0;
    io(1'b1, 2'h3, 8'h12); io(1'b1, 2'h3, 8'h34); io(1'b1, 2'h3, 8'h56);
    chk("cmd addr", 24'h123456, command_addr);
  endtask
  initial begin
    reset = 1'b1; reset_n_pin = 1'b1; cs_n = 1'b1; h_rd_n = 1'b1; h_wr_n = 1'b1; h_a = 2'h0; h_d = 8'h00;
    byte_word = 1'b1; dma_start = 1'b0; dma_write = 1'b0; dma_addr = 24'h0; command_request = 1'b0;
    irq_clear = 1'b0; packet_received = 1'b0; command_done = 1'b0; wr_valid = 1'b0; wr_data = 16'h0;
    rd_ready = 1'b0; slow = 1'b1; n_fail = 0; num_checks = 0;
    cyc(3);
    reset = 1'b0;
    t_reset;
    t_irq;
    t_dma_wr;
    t_dma_rd;
    t_cmd;
    finish_test;
  end
endmodule
`default_nettype wire
